/* hdl/ipdm_top.sv */
// code point priority map: register port, frame lookup and checks
`timescale 1ns/100ps
module ipdm_top
  import ipdm_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic clkEn, // freezes all state while low
  input wire logic [ADDR_W-1:0] regAddr, // register offset
  input wire logic [DATA_W-1:0] regWrData, // write data
  input wire logic regWrStb, // write strobe
  input wire logic regRdStb, // read strobe
  output logic [DATA_W-1:0] regRdData, // read data, cycle after strobe
  input wire logic frameValid, // classifier presents a frame
  input wire logic frameIsIpv4, // frame is IPv4
  input wire logic frameIsIpv6, // frame is IPv6
  input wire logic [7:0] frameTos, // TOS or Traffic Class byte
  output logic prioValid, // result pulse
  output logic [ENTRY_W-1:0] prioOut, // looked up priority
  output logic prioMapped // priority came from the table
);
  typedef struct packed {
    logic [DATA_W-1:0] rdData;
    logic prioValid;
    logic [ENTRY_W-1:0] prio;
    logic prioMapped;
  } ipdm_top_state_t;
  localparam ipdm_top_state_t TOP_RESET = '{rdData: READ_IDLE, prioValid: 1'b0,
    prio: PRIO_NONE, prioMapped: 1'b0};

  ipdm_top_state_t st_q;
  ipdm_top_state_t st_d;
  logic inMap;
  logic isIp;

  ipdm_tbl_if tblIf ();

  ipdm_code_decode u_decode (
    .tblIf (tblIf)
  );

  ipdm_map_table u_table (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .tblIf (tblIf)
  );

  // whole upper nibble range 0x90..0x9F is the map
  // successive bytes index
  assign inMap = (regAddr[ADDR_W-1:IDX_W] == OFS_CODES_00_03[ADDR_W-1:IDX_W]);
  assign isIp = frameIsIpv4 | frameIsIpv6;

  assign tblIf.wrEn = clkEn & regWrStb & inMap;
  assign tblIf.wrIdx = regAddr[IDX_W-1:0];
  assign tblIf.wrData = regWrData;
  assign tblIf.rdIdx = regAddr[IDX_W-1:0];

  assign tblIf.code = frameTos[CODE_MSB:CODE_LSB];

  always_comb
  begin
    st_d = st_q;
    if (clkEn)
    begin
      // read data stand one cycle only
      st_d.rdData = READ_IDLE;
      if (regRdStb && inMap)
      begin
        st_d.rdData = tblIf.rdData;
      end
      st_d.prioValid = frameValid;
      st_d.prioMapped = 1'b0;
      st_d.prio = PRIO_NONE;
      if (frameValid && isIp)
      begin
        st_d.prioMapped = 1'b1;
        st_d.prio = tblIf.entryPri;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_q <= TOP_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign regRdData = st_q.rdData;
  assign prioValid = st_q.prioValid;
  assign prioOut = st_q.prio;
  assign prioMapped = st_q.prioMapped;

  // helpers for the checks below
  logic ipFrame;
  logic mapWrite;
  logic mapRead;
  assign ipFrame = clkEn & frameValid & isIp;
  assign mapWrite = clkEn & regWrStb & inMap;
  assign mapRead = clkEn & regRdStb & inMap;

  function automatic logic [ENTRY_W-1:0] laneOf(logic [DATA_W-1:0] b, logic [1:0] s);
    return b[{s, 1'b0} +: ENTRY_W];
  endfunction

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // low TOS bits never change the result
  property p_code_bits;
    (ipFrame && !regWrStb) ##1
    (ipFrame && !regWrStb && frameTos[CODE_MSB:CODE_LSB] == $past(frameTos[CODE_MSB:CODE_LSB]))
    |=> (prioOut == $past(prioOut));
  endproperty
  a_code_bits: assert property (p_code_bits)
    else $error("priority depends on low TOS bits");

  property p_onehot;
    $onehot(tblIf.codeSel) && tblIf.codeSel[tblIf.code];
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("code select is not a single matching entry");

  property p_lookup;
    ipFrame |=> (prioValid && prioMapped && prioOut == $past(tblIf.entryPri));
  endproperty
  a_lookup: assert property (p_lookup)
    else $error("priority differs from selected entry");

  // byte written, then frame hits one of its four codes
  property p_lane;
    (mapWrite && regAddr == OFS_CODES_00_03) ##1
    (ipFrame && !regWrStb && frameTos[CODE_MSB:4] == 4'h0)
    |=> (prioOut == laneOf($past(regWrData, 2), $past(frameTos[3:2])));
  endproperty
  a_lane: assert property (p_lane)
    else $error("entry lane order wrong in first byte");

  property p_low_regs;
    (mapWrite && regAddr <= OFS_CODES_20_23) ##1
    (ipFrame && !regWrStb && frameTos[CODE_MSB:4] == $past(regAddr[IDX_W-1:0]))
    |=> (prioOut == laneOf($past(regWrData, 2), $past(frameTos[3:2])));
  endproperty
  a_low_regs: assert property (p_low_regs)
    else $error("byte 0x90..0x98 does not map its codes");

  property p_high_regs;
    (mapWrite && regAddr >= OFS_CODES_24_27) ##1
    (ipFrame && !regWrStb && frameTos[CODE_MSB:4] == $past(regAddr[IDX_W-1:0]))
    |=> (prioOut == laneOf($past(regWrData, 2), $past(frameTos[3:2])));
  endproperty
  a_high_regs: assert property (p_high_regs)
    else $error("byte 0x99..0x9F does not map its codes");

  property p_readback;
    mapWrite ##1 (mapRead && regAddr == $past(regAddr))
    |=> (regRdData == $past(regWrData, 2));
  endproperty
  a_readback: assert property (p_readback)
    else $error("map byte does not read back");

  property p_reset_zero;
    disable iff (1'b0)
    sys_rst ##1 (!sys_rst && mapRead) |=> (regRdData == MAP_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("map byte not zero after reset");

  property p_versions;
    (ipFrame && !regWrStb && frameIsIpv4 && !frameIsIpv6) ##1
    (ipFrame && !regWrStb && frameIsIpv6 && !frameIsIpv4 &&
     frameTos[CODE_MSB:CODE_LSB] == $past(frameTos[CODE_MSB:CODE_LSB]))
    |=> (prioOut == $past(prioOut));
  endproperty
  a_versions: assert property (p_versions)
    else $error("IPv4 and IPv6 map differently");

  property p_non_ip;
    (clkEn && frameValid && !isIp) |=> (prioValid && !prioMapped && prioOut == PRIO_NONE);
  endproperty
  a_non_ip: assert property (p_non_ip)
    else $error("table priority applied to non-IP frame");

  property p_write_next;
    (mapWrite && regAddr[IDX_W-1:0] == frameTos[CODE_MSB:4] && ipFrame)
    |=> (prioOut == laneOf($past(tblIf.rdData), $past(frameTos[3:2])));
  endproperty
  a_write_next: assert property (p_write_next)
    else $error("frame in write cycle saw new value");

  property p_read_once;
    (clkEn && !regRdStb) |=> (regRdData == READ_IDLE);
  endproperty
  a_read_once: assert property (p_read_once)
    else $error("read data stood beyond one cycle");

  property p_freeze;
    !clkEn |=> ($stable(regRdData) && $stable(prioOut) && $stable(prioValid));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  property p_cov_write_lookup;
    mapWrite ##1 ipFrame ##1 (prioOut != PRIO_NONE);
  endproperty
  c_write_lookup: cover property (p_cov_write_lookup);

  property p_cov_high_code;
    ipFrame && frameTos[CODE_MSB:CODE_LSB] == 6'h3F;
  endproperty
  c_high_code: cover property (p_cov_high_code);

  property p_cov_readback;
    mapWrite ##1 mapRead ##1 (regRdData != READ_IDLE);
  endproperty
  c_readback: cover property (p_cov_readback);

  property p_cov_non_ip;
    clkEn && frameValid && !isIp;
  endproperty
  c_non_ip: cover property (p_cov_non_ip);
endmodule

/* hdl/ipdm_pkg.sv */
// constants shared by the code point priority map
package ipdm_pkg;
  localparam int CODE_W = 6;
  localparam int CODE_LSB = 2;
  localparam int CODE_MSB = 7;
  localparam int ENTRY_W = 2;
  localparam int ENTRIES = 64;
  localparam int CODES_PER_REG = 4;
  localparam int MAP_REGS = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int IDX_W = 4;
  localparam logic [7:0] OFS_CODES_00_03 = 8'h90;
  localparam logic [7:0] OFS_CODES_04_07 = 8'h91;
  localparam logic [7:0] OFS_CODES_08_0B = 8'h92;
  localparam logic [7:0] OFS_CODES_0C_0F = 8'h93;
  localparam logic [7:0] OFS_CODES_10_13 = 8'h94;
  localparam logic [7:0] OFS_CODES_14_17 = 8'h95;
  localparam logic [7:0] OFS_CODES_18_1B = 8'h96;
  localparam logic [7:0] OFS_CODES_1C_1F = 8'h97;
  localparam logic [7:0] OFS_CODES_20_23 = 8'h98;
  localparam logic [7:0] OFS_CODES_24_27 = 8'h99;
  localparam logic [7:0] OFS_CODES_28_2B = 8'h9A;
  localparam logic [7:0] OFS_CODES_2C_2F = 8'h9B;
  localparam logic [7:0] OFS_CODES_30_33 = 8'h9C;
  localparam logic [7:0] OFS_CODES_34_37 = 8'h9D;
  localparam logic [7:0] OFS_CODES_38_3B = 8'h9E;
  localparam logic [7:0] OFS_CODES_3C_3F = 8'h9F;
  localparam logic [7:0] MAP_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic [1:0] PRIO_NONE = 2'h0;
endpackage

/* hdl/ipdm_tbl_if.sv */
// carrier between the map control, the code decoder and the table
`timescale 1ns/100ps
interface ipdm_tbl_if;
  import ipdm_pkg::*;
  logic wrEn;
  logic [IDX_W-1:0] wrIdx;
  logic [DATA_W-1:0] wrData;
  logic [IDX_W-1:0] rdIdx;
  logic [DATA_W-1:0] rdData;
  logic [CODE_W-1:0] code;
  logic [ENTRIES-1:0] codeSel;
  logic [ENTRY_W-1:0] entryPri;
  modport ctrl (output wrEn, output wrIdx, output wrData, output rdIdx, output code,
    input rdData, input entryPri, input codeSel);
  modport dec (input code, output codeSel);
  modport store (input wrEn, input wrIdx, input wrData, input rdIdx, input codeSel,
    output rdData, output entryPri);
endinterface

/* hdl/ipdm_code_decode.sv */
// full decode of the six bit code point into one select per entry
`timescale 1ns/100ps
module ipdm_code_decode
  import ipdm_pkg::*;
(
  ipdm_tbl_if.dec tblIf // code in, one-hot select out
);
  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++)
    begin : g_sel
      assign tblIf.codeSel[gi] = (tblIf.code == CODE_W'(gi));
    end
  endgenerate
endmodule

/* hdl/ipdm_map_table.sv */
// sixteen mapping bytes, four two bit entries each
`timescale 1ns/100ps
module ipdm_map_table
  import ipdm_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic sys_rst, // synchronous reset, active high
  ipdm_tbl_if.store tblIf // write, readback and lookup
);
  typedef struct packed {
    logic [MAP_REGS-1:0][DATA_W-1:0] mapReg;
  } ipdm_tbl_state_t;
  localparam ipdm_tbl_state_t TBL_RESET = '{mapReg: {MAP_REGS{MAP_RESET}}};

  ipdm_tbl_state_t st_q;
  ipdm_tbl_state_t st_d;
  logic [ENTRIES*ENTRY_W-1:0] flat;
  logic [ENTRIES-1:0][ENTRY_W-1:0] masked;

  always_comb
  begin
    st_d = st_q;
    if (tblIf.wrEn)
    begin
      st_d.mapReg[tblIf.wrIdx] = tblIf.wrData;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_q <= TBL_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign tblIf.rdData = st_q.mapReg[tblIf.rdIdx];
  assign flat = st_q.mapReg;

  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++)
    begin : g_pick
      assign masked[gi] = tblIf.codeSel[gi] ? flat[gi*ENTRY_W +: ENTRY_W] : PRIO_NONE;
    end
  endgenerate

  always_comb
  begin
    tblIf.entryPri = PRIO_NONE;
    for (int i = 0; i < ENTRIES; i++)
    begin
      tblIf.entryPri = tblIf.entryPri | masked[i];
    end
  end
endmodule

/* dv/testbench.sv */
// self-checking bench for the code point priority map
`timescale 1ns/100ps
module testbench;
  import ipdm_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic [ADDR_W-1:0] regAddr = 8'h00;
  logic [DATA_W-1:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic frameValid = 1'b0;
  logic frameIsIpv4 = 1'b0;
  logic frameIsIpv6 = 1'b0;
  logic [7:0] frameTos = 8'h00;
  logic prioValid;
  logic [ENTRY_W-1:0] prioOut;
  logic prioMapped;
  int mismatches = 0;
  int nTests = 0;
  logic [7:0] expMap [MAP_REGS];

  ipdm_top u_ipdm_top (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrStb(regWrStb),
    .regRdStb(regRdStb),
    .regRdData(regRdData),
    .frameValid(frameValid),
    .frameIsIpv4(frameIsIpv4),
    .frameIsIpv6(frameIsIpv6),
    .frameTos(frameTos),
    .prioValid(prioValid),
    .prioOut(prioOut),
    .prioMapped(prioMapped)
  );

  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chkByte(string what, logic [7:0] expv, logic [7:0] got);
    nTests++;
    if (got !== expv)
    begin
      $display("wrong value %s expected %h seen %h", what, expv, got);
      mismatches++;
    end
  endtask

  task automatic chkPrio(logic expM, logic [1:0] expP);
    nTests++;
    if ({prioValid, prioMapped, prioOut} !== {1'b1, expM, expP})
    begin
      $display("wrong value prio expected %b seen %b", {1'b1, expM, expP},
        {prioValid, prioMapped, prioOut});
      mismatches++;
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask

  // data only in the cycle after the strobe, idle value after that
  task automatic rd(logic [7:0] a, logic [7:0] expv);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1;
    chkByte("read data", expv, regRdData);
    @(posedge ref_clk);
    #1;
    chkByte("read idle", READ_IDLE, regRdData);
  endtask

  task automatic frame(logic v4, logic v6, logic [7:0] tos, logic expM, logic [1:0] expP);
    @(posedge ref_clk);
    frameValid <= 1'b1;
    frameIsIpv4 <= v4;
    frameIsIpv6 <= v6;
    frameTos <= tos;
    @(posedge ref_clk);
    frameValid <= 1'b0;
    #1;
    chkPrio(expM, expP);
  endtask

  // write, then read back and look up the same byte at once
  task automatic wrUse(logic [7:0] a, logic [7:0] d, logic [1:0] lane);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
    regRdStb <= 1'b1;
    frameValid <= 1'b1;
    frameIsIpv4 <= lane[0];
    frameIsIpv6 <= !lane[0];
    frameTos <= {a[3:0], lane, 2'b10};
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    frameValid <= 1'b0;
    #1;
    chkByte("read at once", d, regRdData);
    chkPrio(1'b1, d[2 * lane +: 2]);
  endtask

  initial
  begin
    #(40 * 20000);
    $display("run limit reached");
    mismatches++;
    conclude();
  end

  initial
  begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    chkByte("reset read data", READ_IDLE, regRdData);
    chkByte("reset outputs", 8'h00, {4'h0, prioValid, prioMapped, prioOut});
    wr(8'h8F, 8'hFF);
    wr(8'hA0, 8'hFF);
    rd(8'h8F, READ_IDLE);
    rd(8'hA0, READ_IDLE);
    for (int k = 0; k < MAP_REGS; k++)
      rd(8'(8'h90 + k), MAP_RESET);
    frame(1'b1, 1'b0, 8'hFC, 1'b1, PRIO_NONE);
    $display("test reset done");
    for (int k = 0; k < MAP_REGS; k++)
    begin
      expMap[k] = 8'(k * 27) ^ 8'hE4;
      wr(8'(8'h90 + k), expMap[k]);
    end
    for (int k = 0; k < MAP_REGS; k++)
      rd(8'(8'h90 + k), expMap[k]);
    $display("test readback done");
    // back to back frames, both versions, noise in the low tos bits
    for (int i = 0; i <= ENTRIES; i++)
    begin
      @(posedge ref_clk);
      frameValid <= (i < ENTRIES);
      frameIsIpv4 <= i[0];
      frameIsIpv6 <= !i[0];
      frameTos <= {i[5:0], ~i[1:0]};
      #1;
      if (i > 0)
        chkPrio(1'b1, expMap[(i - 1) / 4][2 * ((i - 1) % 4) +: 2]);
    end
    @(posedge ref_clk);
    #1;
    chkByte("prio idle", 8'h00, {4'h0, prioValid, prioMapped, prioOut});
    frame(1'b0, 1'b0, 8'hFF, 1'b0, PRIO_NONE);
    frame(1'b1, 1'b1, 8'hFF, 1'b1, expMap[15][7:6]);
    // same code twice, other version and low bits: same result
    for (int i = 0; i <= 2; i++)
    begin
      @(posedge ref_clk);
      frameValid <= (i < 2);
      frameIsIpv4 <= (i == 0);
      frameIsIpv6 <= (i != 0);
      frameTos <= {6'h25, i[1:0] ^ 2'b11};
      #1;
      if (i > 0)
        chkPrio(1'b1, expMap[9][3:2]);
    end
    $display("test lookup done");
    // write and frame in one cycle: frame still sees the old entry
    @(posedge ref_clk);
    regAddr <= OFS_CODES_00_03;
    regWrData <= ~expMap[0];
    regWrStb <= 1'b1;
    frameValid <= 1'b1;
    frameIsIpv4 <= 1'b1;
    frameIsIpv6 <= 1'b0;
    frameTos <= 8'h00;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
    frameValid <= 1'b0;
    #1;
    chkPrio(1'b1, expMap[0][1:0]);
    expMap[0] = ~expMap[0];
    frame(1'b0, 1'b1, 8'h03, 1'b1, expMap[0][1:0]);
    $display("test write order done");
    // strobe while frozen is dropped
    @(posedge ref_clk);
    clkEn <= 1'b0;
    regAddr <= OFS_CODES_04_07;
    regWrData <= ~expMap[1];
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
    clkEn <= 1'b1;
    rd(OFS_CODES_04_07, expMap[1]);
    $display("test freeze done");
    wrUse(OFS_CODES_00_03, 8'h1B, 2'h2);
    wrUse(OFS_CODES_20_23, 8'hC6, 2'h1);
    wrUse(OFS_CODES_3C_3F, 8'h93, 2'h3);
    $display("test write then use done");
    // reset in mid-run clears the table; read in the very first cycle
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    regAddr <= OFS_CODES_3C_3F;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1;
    chkByte("read after reset", MAP_RESET, regRdData);
    frame(1'b1, 1'b0, 8'hFC, 1'b1, PRIO_NONE);
    $display("test mid reset done");
    conclude();
  end
endmodule
